// *** hw/adc_cfg_pkg.sv ***
// constants and types for the converter configuration block
package adc_cfg_pkg;

	localparam int DATA_W = 16;
	localparam int CFG_W = 32;
	localparam int ADDR_W = 4;
	localparam int NPAIR = 3;
	localparam int FULL_RES = 16;
	localparam int MEM_AW = 3;
	localparam int MEM_DEPTH = 8;

	// config word layout
	localparam logic [31:0] CFG_RESET = 32'h0000_03FF;
	localparam int REF_ON_BIT = 25;
	// span bit of pair p sits at RANGE_A_BIT - p
	localparam int RANGE_A_BIT = 28;

	// register port offsets
	localparam logic [3:0] OFS_CONFIG = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;

	// last result index of a read sweep
	localparam logic [2:0] LAST_RESULT = 3'h5;

	typedef enum logic {PH_IDLE, PH_SECOND} phase_t;

endpackage

// *** hw/adc_mode_config.sv ***
// pin and config-word driven mode logic of the six-channel converter
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/100ps
module adc_mode_config #(
	parameter int RESOLUTION = 16
) (
	// clock and reset
	input  wire logic                              mclk,
	input  wire logic                              sys_rst,
	// static mode selects
	input  wire logic                              interface_select,
	input  wire logic                              config_source_select,
	// configuration pins
	input  wire logic                              ref_strobe_pin,
	input  wire logic                              range_pin,
	// parallel bus
	input  wire logic                              cs_n,
	input  wire logic                              rd_n,
	input  wire logic [adc_cfg_pkg::DATA_W-1:0]    db_in,
	output logic      [adc_cfg_pkg::DATA_W-1:0]    db_out,
	output logic                                   db_oe_n,
	// serial link
	input  wire logic                              frame_sync_n,
	input  wire logic                              sclk,
	output logic      [adc_cfg_pkg::NPAIR-1:0]     serial_out_x,
	output logic                                   serial_oe_n,
	// conversion control and converter core
	input  wire logic [adc_cfg_pkg::NPAIR-1:0]     pair_conversion_trigger,
	output logic                                   busy,
	output logic      [adc_cfg_pkg::NPAIR-1:0]     core_start,
	input  wire logic                              core_done,
	input  wire logic [1:0]                        core_pair,
	input  wire logic [adc_cfg_pkg::DATA_W-1:0]    core_code0,
	input  wire logic [adc_cfg_pkg::DATA_W-1:0]    core_code1,
	// analog settings
	output logic                                   internal_ref_enable,
	output logic      [adc_cfg_pkg::NPAIR-1:0]     range_sel,
	// register port
	input  wire logic [adc_cfg_pkg::ADDR_W-1:0]    reg_addr,
	input  wire logic [adc_cfg_pkg::CFG_W-1:0]     reg_wdata,
	input  wire logic                              reg_wr,
	input  wire logic                              reg_rd,
	output logic      [adc_cfg_pkg::CFG_W-1:0]     reg_rdata
);
	import adc_cfg_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [CFG_W-1:0]             cfg;
		logic [DATA_W-1:0]            hi_half;
		logic                         word_ph;
		logic [NPAIR-1:0]             pend;
		logic [NPAIR-1:0]             trig_q;
		logic                         busy;
		logic [NPAIR-1:0]             core_start;
		logic                         wr_q;
		logic                         rd_q;
		logic                         fs_q;
		logic                         sclk_q;
		logic [MEM_AW-1:0]            rd_ptr;
		logic [DATA_W-1:0]            db_out;
		logic                         db_oe_n;
		logic [NPAIR-1:0][2*DATA_W-1:0] sh;
		logic                         ser_oe_n;
		logic [NPAIR-1:0]             ser_out;
		logic                         ref_en;
		logic [NPAIR-1:0]             range_sel;
		logic [CFG_W-1:0]             reg_rdata;
		phase_t                       phase;
		logic [DATA_W-1:0]            code1;
		logic [1:0]                   wpair;
		logic                         mem_we;
		logic [MEM_AW-1:0]            mem_waddr;
		logic [DATA_W-1:0]            mem_wdata;
	} state_t;

	state_t s;
	state_t next_s;

	logic                hw_mode;
	logic                par_mode;
	logic                par_wr;
	logic                par_rd;
	logic                wr_fall;
	logic                rd_fall;
	logic                fs_fall;
	logic                sclk_rise;
	logic [NPAIR-1:0]    rise;
	logic [NPAIR-1:0]    done_mask;
	logic [DATA_W-1:0]   mem_rdata;
	logic [DATA_W-1:0]   top_mask;
	logic                cfg_reg_wr;

	assign hw_mode = ~config_source_select;
	assign par_mode = ~interface_select;
	// strobe pin is a store strobe only in word mode on the parallel bus
	assign par_wr = config_source_select & par_mode & ~cs_n & ~ref_strobe_pin;
	assign par_rd = par_mode & ~cs_n & ~rd_n;
	assign wr_fall = par_wr & ~s.wr_q;
	assign rd_fall = par_rd & ~s.rd_q;
	assign fs_fall = ~frame_sync_n & s.fs_q;
	assign sclk_rise = sclk & ~s.sclk_q;
	assign rise = pair_conversion_trigger & ~s.trig_q;
	assign done_mask = core_done ? NPAIR'(3'h1 << core_pair) : '0;
	assign cfg_reg_wr = reg_wr & (reg_addr == OFS_CONFIG);
	assign top_mask = (RESOLUTION < FULL_RES) ? 16'h7FFF : 16'hFFFF;

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_s = s;
		next_s.trig_q = pair_conversion_trigger;
		next_s.wr_q = par_wr;
		next_s.rd_q = par_rd;
		next_s.fs_q = frame_sync_n;
		next_s.sclk_q = sclk;
		next_s.mem_we = 1'b0;
		next_s.reg_rdata = '0;

		// conversion start and completion, a new start wins over a done
		next_s.pend = (s.pend & ~done_mask) | rise;
		next_s.core_start = rise;
		next_s.busy = |next_s.pend;

		// results: two writes per completed pair
		unique case (s.phase)
			PH_IDLE: begin
				if (core_done) begin
					next_s.mem_we = 1'b1;
					next_s.mem_waddr = {core_pair, 1'b0};
					next_s.mem_wdata = core_code0;
					next_s.code1 = core_code1;
					next_s.wpair = core_pair;
					next_s.phase = PH_SECOND;
					next_s.sh[core_pair] = {core_code0, core_code1};
				end
			end
			PH_SECOND: begin
				next_s.mem_we = 1'b1;
				next_s.mem_waddr = {s.wpair, 1'b1};
				next_s.mem_wdata = s.code1;
				next_s.phase = PH_IDLE;
			end
		endcase

		// read sweep restarts once all pairs are done
		if (s.busy && !next_s.busy) begin
			next_s.rd_ptr = '0;
		end

		// analog settings from pins or word
		if (hw_mode) begin
			next_s.ref_en = ref_strobe_pin;
			next_s.range_sel = {NPAIR{range_pin}};
		end else begin
			next_s.ref_en = s.cfg[REF_ON_BIT];
			for (int i = 0; i < NPAIR; i++) begin
				next_s.range_sel[i] = s.cfg[RANGE_A_BIT-i];
			end
		end

		// parallel store: upper half first, lower half commits
		if (wr_fall) begin
			if (!s.word_ph) begin
				next_s.hi_half = db_in;
				next_s.word_ph = 1'b1;
			end else begin
				next_s.cfg = {s.hi_half, db_in};
				next_s.word_ph = 1'b0;
			end
		end
		if (cfg_reg_wr) begin
			next_s.cfg = reg_wdata;
			next_s.word_ph = 1'b0;
		end

		// parallel read
		next_s.db_oe_n = ~par_rd;
		if (rd_fall) begin
			next_s.db_out = mem_rdata & top_mask;
			next_s.rd_ptr = (s.rd_ptr == LAST_RESULT) ? '0 : s.rd_ptr + 3'h1;
		end

		// serial frames, ignored while converting
		// a refused frame stays quiet until frame_sync_n rises again
		if (frame_sync_n || !interface_select) begin
			next_s.ser_oe_n = 1'b1;
			next_s.ser_out = '0;
		end else if (fs_fall && !s.busy) begin
			next_s.ser_oe_n = 1'b0;
			for (int i = 0; i < NPAIR; i++) begin
				next_s.ser_out[i] = s.sh[i][2*DATA_W-1];
			end
		end else if (!s.ser_oe_n && sclk_rise) begin
			for (int i = 0; i < NPAIR; i++) begin
				next_s.sh[i] = {s.sh[i][2*DATA_W-2:0], 1'b0};
				next_s.ser_out[i] = s.sh[i][2*DATA_W-2];
			end
		end

		// register reads
		if (reg_rd) begin
			unique case (reg_addr)
				OFS_CONFIG: next_s.reg_rdata = s.cfg;
				OFS_STATUS: next_s.reg_rdata = {20'h0_0000, s.word_ph, s.pend,
					s.range_sel, s.ref_en, config_source_select,
					interface_select, s.busy, 1'b0};
				default: next_s.reg_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '0;
			s.cfg <= CFG_RESET;
			s.db_oe_n <= 1'b1;
			s.ser_oe_n <= 1'b1;
			// store, read and trigger samples read as held so release starts none; fs_q reads high, so a low frame_sync_n starts a frame
			s.wr_q <= 1'b1;
			s.rd_q <= 1'b1;
			s.fs_q <= 1'b1;
			s.trig_q <= '1;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// result memory and outputs

	// two write cycles per pair, so done pulses must come at least two apart
	result_store u_store (
		.mclk  (mclk),
		.we    (s.mem_we),
		.waddr (s.mem_waddr),
		.wdata (s.mem_wdata),
		.raddr (s.rd_ptr),
		.rdata (mem_rdata)
	);

	assign db_out = s.db_out;
	assign db_oe_n = s.db_oe_n;
	assign serial_out_x = s.ser_out;
	assign serial_oe_n = s.ser_oe_n;
	assign busy = s.busy;
	assign core_start = s.core_start;
	assign internal_ref_enable = s.ref_en;
	assign range_sel = s.range_sel;
	assign reg_rdata = s.reg_rdata;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// reference and span selection
	a_ref_pin_on: assert property (hw_mode && ref_strobe_pin |=> internal_ref_enable)
		else $error("reference not on with pin high");
	a_ref_pin_off: assert property (hw_mode && !ref_strobe_pin |=> !internal_ref_enable)
		else $error("reference not off with pin low");
	a_ref_word: assert property (config_source_select |=>
		internal_ref_enable == $past(s.cfg[REF_ON_BIT]))
		else $error("reference does not follow word bit");
	a_range_pin: assert property (hw_mode |=> range_sel == {NPAIR{$past(range_pin)}})
		else $error("span does not follow pin");
	a_range_word: assert property (config_source_select |=>
		range_sel[1] == $past(s.cfg[RANGE_A_BIT-1]))
		else $error("span does not follow word bit");
	for (genvar p = 0; p < NPAIR; p++) begin : g_span
		a_span_pair: assert property (config_source_select |=>
			range_sel[p] == $past(s.cfg[RANGE_A_BIT-p]))
			else $error("pair span does not follow its word bit");
	end

	// bus ownership and data
	a_par_quiet: assert property (interface_select |=> db_oe_n)
		else $error("parallel bus driven in serial mode");
	a_ser_quiet: assert property (!interface_select |=> serial_oe_n)
		else $error("serial output driven in parallel mode");
	a_par_drive: assert property (par_rd |=> !db_oe_n)
		else $error("parallel bus not driven during read");
	a_db_release: assert property (!par_rd |=> db_oe_n)
		else $error("parallel bus driven outside a read");
	a_rd_index: assert property (s.rd_ptr <= LAST_RESULT)
		else $error("read index past last result");
	a_top_bit: assert property ((RESOLUTION < FULL_RES) |-> !db_out[DATA_W-1])
		else $error("top data bit not zero");

	// config word stores
	a_cfg_source: assert property (s.cfg != $past(s.cfg) |->
		$past(wr_fall && s.word_ph || cfg_reg_wr))
		else $error("config word changed without a store");
	a_cfg_commit: assert property (wr_fall && s.word_ph && !cfg_reg_wr |=>
		s.cfg == {$past(s.hi_half), $past(db_in)})
		else $error("stored config word differs from its halves");
	a_store_ignored: assert property (hw_mode || interface_select |=>
		s.cfg == $past(s.cfg) || $past(cfg_reg_wr))
		else $error("strobe pin stored data outside parallel word mode");

	// conversion and serial frames
	a_frame_idle: assert property ($fell(serial_oe_n) |-> !$past(busy))
		else $error("frame started while busy");
	a_ser_start: assert property (fs_fall && !busy && interface_select |=>
		!serial_oe_n)
		else $error("frame not started after frame sync");
	a_frame_refused: assert property (fs_fall && busy |=> serial_oe_n)
		else $error("frame started while converting");
	a_frame_end: assert property (frame_sync_n |=> serial_oe_n)
		else $error("serial output still driven after frame");
	a_busy_start: assert property (|rise |=> busy && core_start == $past(rise))
		else $error("busy or start pulse missing after trigger");
	a_core_start: assert property (|core_start |-> busy)
		else $error("start pulse without busy");
	a_busy_clear: assert property (core_done && !(|rise) &&
		(s.pend & ~done_mask) == '0 |=> !busy)
		else $error("busy still high after last pair done");

	c_par_read: cover property (rd_fall ##1 !db_oe_n);
	c_word_store: cover property (wr_fall && s.word_ph);
	c_frame: cover property ($fell(serial_oe_n) ##[1:8] sclk_rise);
	c_frame_refused: cover property (fs_fall && busy);
	c_conv_done: cover property ($fell(busy));

endmodule

// *** hw/result_store.sv ***
// small result memory with registered read data
`timescale 1ns/100ps
module result_store (
	// clock
	input  wire logic                              mclk,
	// write side
	input  wire logic                              we,
	input  wire logic [adc_cfg_pkg::MEM_AW-1:0]    waddr,
	input  wire logic [adc_cfg_pkg::DATA_W-1:0]    wdata,
	// read side
	input  wire logic [adc_cfg_pkg::MEM_AW-1:0]    raddr,
	output logic      [adc_cfg_pkg::DATA_W-1:0]    rdata
);
	import adc_cfg_pkg::*;

	logic [DATA_W-1:0] mem [MEM_DEPTH];

	always_ff @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end

endmodule

// *** verification/adc_mode_config_tb.sv ***
// self-checking bench for the converter mode and config logic
`timescale 1ns/100ps
module adc_mode_config_tb;
	import adc_cfg_pkg::*;

	localparam int RES = 14;

	logic              mclk, sys_rst, interface_select, config_source_select;
	logic              ref_strobe_pin, range_pin, cs_n, rd_n, db_oe_n, frame_sync_n, sclk;
	logic              serial_oe_n, busy, internal_ref_enable, reg_wr, reg_rd;
	logic              core_done = 1'b0;
	logic [1:0]        core_pair = 2'h0;
	logic [15:0]       db_in, db_out;
	logic [15:0]       core_code0 = 16'h0000;
	logic [15:0]       core_code1 = 16'h0000;
	logic [NPAIR-1:0]  serial_out_x, pair_conversion_trigger, core_start, range_sel;
	logic [NPAIR-1:0]  pend = '0;
	logic [3:0]        reg_addr;
	logic [31:0]       reg_wdata, reg_rdata;
	logic [2:0]        gap = 3'h0;
	logic [15:0]       code [NPAIR][2];
	int                cp, n_mismatch, check_count;

	adc_mode_config #(.RESOLUTION(RES)) uut (.mclk, .sys_rst, .interface_select,
		.config_source_select, .ref_strobe_pin, .range_pin, .cs_n, .rd_n, .db_in, .db_out,
		.db_oe_n, .frame_sync_n, .sclk, .serial_out_x, .serial_oe_n,
		.pair_conversion_trigger, .busy, .core_start, .core_done, .core_pair, .core_code0,
		.core_code1, .internal_ref_enable, .range_sel, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata);

	serial_host_model hm (.mclk, .busy, .serial_out_x, .serial_oe_n, .frame_sync_n, .sclk);

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////
	// converter core: answers pending pairs, lowest first
	always @(posedge mclk) begin
		core_done <= 1'b0;
		pend = sys_rst ? '0 : pend | core_start;
		gap <= gap + 3'h1;
		if (gap == 3'h7 && pend != '0) begin
			for (int p = NPAIR - 1; p >= 0; p--)
				if (pend[p])
					cp = p;
			pend[cp] = 1'b0;
			core_done <= 1'b1;
			core_pair <= 2'(cp);
			core_code0 <= code[cp][0];
			core_code1 <= code[cp][1];
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic do_reset(input logic isel, csel);
		@(posedge mclk);
		sys_rst <= 1'b1;
		interface_select <= isel;
		config_source_select <= csel;
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// two stores: upper half, then lower half
	task automatic pwrite(input logic [31:0] w, input logic sel_n);
		@(posedge mclk);
		cs_n <= sel_n;
		ref_strobe_pin <= 1'b0;
		db_in <= w[31:16];
		@(posedge mclk);
		ref_strobe_pin <= 1'b1;
		@(posedge mclk);
		ref_strobe_pin <= 1'b0;
		db_in <= w[15:0];
		@(posedge mclk);
		ref_strobe_pin <= 1'b1;
		cs_n <= 1'b1;
	endtask

	task automatic pread(output logic [15:0] d);
		@(posedge mclk);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		repeat (2) @(posedge mclk);
		#1 d = db_out;
		check(32'(db_oe_n), 32'(interface_select));
		@(posedge mclk);
		rd_n <= 1'b1;
		cs_n <= 1'b1;
		@(posedge mclk);
	endtask

	task automatic convert(input logic [NPAIR-1:0] m);
		int n;
		for (int p = 0; p < NPAIR; p++) begin
			code[p][0] = 16'($urandom) | 16'h8000;
			code[p][1] = 16'($urandom);
		end
		@(posedge mclk);
		pair_conversion_trigger <= m;
		repeat (3) @(posedge mclk);
		#1 check(32'(busy), 32'h1);
		@(posedge mclk);
		pair_conversion_trigger <= '0;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (busy !== 1'b0 && n < 300);
		if (n >= 300) begin
			n_mismatch++;
			finish_test();
		end
		repeat (4) @(posedge mclk);
	endtask

	function automatic logic [31:0] exp_par(input logic [15:0] c);
		return 32'((RES < 16) ? {1'b0, c[14:0]} : c);
	endfunction

	////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d, w;
		logic [15:0] r;
		logic        ok;
		{sys_rst, ref_strobe_pin, cs_n, rd_n} = 4'hf;
		{interface_select, config_source_select, range_pin, reg_wr, reg_rd} = '0;
		{db_in, reg_addr, reg_wdata, pair_conversion_trigger} = '0;
		void'($urandom(32'h9c1ce1b9));
		do_reset(1'b0, 1'b0);
		reg_read(OFS_CONFIG, d);
		check(d, CFG_RESET);
		reg_read(4'h8, d);
		check(d, 32'h0);
		for (int i = 0; i < 8; i++) begin
			reg_write(OFS_CONFIG, $urandom);
			@(posedge mclk);
			ref_strobe_pin <= i[0];
			range_pin <= 1'($urandom);
			repeat (2) @(posedge mclk);
			#1 check(32'(internal_ref_enable), 32'(ref_strobe_pin));
			check(32'(range_sel), 32'({3{range_pin}}));
		end
		$display("test pin mode done");
		ref_strobe_pin <= 1'b1;
		do_reset(1'b0, 1'b1);
		for (int i = 0; i < 4; i++) begin
			w = $urandom;
			w[25] = i[0];
			reg_write(OFS_CONFIG, w);
			repeat (2) @(posedge mclk);
			#1 check(32'(internal_ref_enable), 32'(w[25]));
			check(32'(range_sel), 32'({w[26], w[27], w[28]}));
		end
		w = $urandom;
		pwrite(w, 1'b0);
		reg_read(OFS_CONFIG, d);
		check(d, w);
		pwrite(~w, 1'b1);
		reg_read(OFS_CONFIG, d);
		check(d, w);
		reg_read(OFS_STATUS, d);
		check(d, {20'h0_0000, 4'h0, w[26], w[27], w[28], w[25], 4'h8});
		convert(3'h7);
		for (int i = 0; i < 6; i++) begin
			pread(r);
			check(32'(r), exp_par(code[i / 2][i % 2]));
		end
		$display("test parallel word mode done");
		ref_strobe_pin <= 1'b0;
		do_reset(1'b1, 1'b1);
		reg_write(OFS_CONFIG, 32'h0200_0000);
		repeat (2) @(posedge mclk);
		#1 check(32'(internal_ref_enable), 32'h1);
		convert(3'h7);
		hm.read_frame(ok);
		check(32'(ok), 32'h1);
		if (!ok)
			finish_test();
		for (int p = 0; p < NPAIR; p++)
			check(hm.lane[p], {code[p][0], code[p][1]});
		@(posedge mclk);
		#1 check(32'(serial_oe_n), 32'h1);
		pread(r);
		@(posedge mclk);
		pair_conversion_trigger <= 3'h7;
		hm.early_frame(ok);
		check(32'(ok), 32'h1);
		#1 check(32'(busy), 32'h1);
		do_reset(1'b1, 1'b1);
		#1 check(32'(busy), 32'h0);
		reg_read(OFS_CONFIG, d);
		check(d, CFG_RESET);
		$display("test serial mode done");
		finish_test();
	end
endmodule

// *** verification/serial_host_model.sv ***
// host model that pulls one serial frame from all three lanes
`timescale 1ns/100ps
module serial_host_model (
	// clock and status
	input  wire logic                          mclk,
	input  wire logic                          busy,
	input  wire logic [adc_cfg_pkg::NPAIR-1:0] serial_out_x,
	input  wire logic                          serial_oe_n,
	// frame control
	output logic                               frame_sync_n,
	output logic                               sclk
);
	import adc_cfg_pkg::*;

	logic [31:0] lane [NPAIR];

	initial begin
		frame_sync_n = 1'b1;
		sclk = 1'b0;
	end

	// sclk stands still outside frames
	task automatic read_frame(output logic ok);
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (busy !== 1'b0 && n < 500);
		ok = (n < 500);
		if (!ok)
			return;
		frame_sync_n <= 1'b0;
		repeat (3) @(posedge mclk);
		for (int b = 31; b >= 0; b--) begin
			for (int p = 0; p < NPAIR; p++)
				lane[p][b] = serial_out_x[p];
			sclk <= 1'b1;
			repeat (2) @(posedge mclk);
			sclk <= 1'b0;
			repeat (2) @(posedge mclk);
		end
		frame_sync_n <= 1'b1;
		@(posedge mclk);
	endtask

	// frame forced while busy, which the device must refuse
	task automatic early_frame(output logic quiet);
		@(posedge mclk);
		frame_sync_n <= 1'b0;
		repeat (3) @(posedge mclk);
		quiet = serial_oe_n;
		frame_sync_n <= 1'b1;
		@(posedge mclk);
	endtask
endmodule
